// ### common/ff_set_pkg.sv
/*
 * Shared types and constants for the storage element set: input and
 * output bundles for each element, captured command codes, reset values.
 * Assumes the surrounding logic drives every bundle field as a plain level.
 */
`default_nettype none

package ff_set_pkg;

   // Value every true output takes after reset
   localparam logic RESET_Q      = 1'b0;
   // Value of the inverted output after reset
   localparam logic RESET_Q_N    = 1'b1;
   // Synchroniser depth for inputs that come from outside the clock domain
   localparam int   SYNC_STAGES  = 2;

   // Set/clear element inputs
   typedef struct packed {
      logic clocked_set_cmd;   // Set command, taken on stage clock rise
      logic clocked_clear_cmd; // Clear command, taken on stage clock rise
      logic stage_clock;       // Stage clock of this element
      logic force_set;         // Static force high, active high
      logic force_clear;       // Static force low, active high
   } sr_in_t;

   // Two-command element inputs
   typedef struct packed {
      logic upper_cmd;         // First command input
      logic lower_cmd;         // Second command input
      logic stage_clock;       // Stage clock of this element
      logic force_set;         // Static force high, active high
      logic force_clear;       // Static force low, active high
   } jk_in_t;

   // Transparent latch inputs
   typedef struct packed {
      logic sample_value;      // Data followed while the clock is high
      logic stage_clock;       // Gate of the latch
   } latch_in_t;

   // Master-slave data element inputs
   typedef struct packed {
      logic sample_value;      // Data taken on stage clock rise
      logic stage_clock;       // Stage clock of this element
      logic force_set;         // Static force high, active high
      logic force_clear;       // Static force low, active high
   } dff_in_t;

   // Output pair of any element
   typedef struct packed {
      logic q;                 // True output
      logic q_n;               // Inverted output
   } ff_out_t;

   // Command held in the set/clear master stage
   typedef enum logic [1:0] {
      SR_HOLD,
      SR_SET,
      SR_CLEAR
   } sr_cmd_t;

   // Command held in the two-command master stage
   typedef enum logic [1:0] {
      JK_KEEP,
      JK_CLEAR,
      JK_SET,
      JK_TOGGLE
   } jk_cmd_t;

   // Total width of all synchronised inputs
   localparam int IN_WIDTH = $bits(sr_in_t) + $bits(jk_in_t)
                           + $bits(latch_in_t) + $bits(dff_in_t);

endpackage : ff_set_pkg

`default_nettype wire

// ### hdl/level_sync.sv
/*
 * Two flip-flop synchroniser for a vector of levels, plus one further
 * delayed copy so the user can find rising and falling edges.
 * Assumes each bit is an independent level; no bus coherence is given.
 */
`default_nettype none

module level_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] prev_o
);

   // Refuse a vector that carries nothing
   if (WIDTH < 1) begin : g_bad_width
      $error("level_sync: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] meta_q, meta_d;   // First stage, read only by second
   logic [WIDTH-1:0] sync_q, sync_d;   // Second stage, safe to use
   logic [WIDTH-1:0] prev_q, prev_d;   // One cycle older copy for edges

   // Next values of the chain
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   // Chain registers; reset clears to low levels
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   assign level_o = sync_q;
   assign prev_o  = prev_q;

endmodule : level_sync

`default_nettype wire

// ### hdl/edge_flip_flop_set.sv
/*
 * Storage element set: a master-slave set/clear flip-flop, a master-slave
 * two-command flip-flop, a transparent latch and a master-slave data
 * flip-flop, each modelled on the system clock from sampled pin levels.
 * Assumes every input comes from outside the clock domain, so each is
 * synchronised before use; stage clocks must stay high and low for at
 * least two system clock cycles each to be seen.
 */
// Notes on behaviour
// - Set/clear master takes command on clock rise.
// - Set/clear slave applies taken command on fall.
// - Force inputs override clock, act at once.
// - Two-command master takes command on clock rise.
// - Two-command slave applies taken command on fall.
// - Keep, clear, set, invert by command pair.
// - Latch output follows data while clock high.
// - Latch holds output while clock stays low.
// - Data master samples input on clock rise.
// - Data slave presents sampled value on fall.
`default_nettype none

module edge_flip_flop_set (
   input  wire logic                  mclk_i,
   input  wire logic                  reset_i,
   input  wire ff_set_pkg::sr_in_t    sr_i,
   input  wire ff_set_pkg::jk_in_t    jk_i,
   input  wire ff_set_pkg::latch_in_t latch_i,
   input  wire ff_set_pkg::dff_in_t   dff_i,
   output var  ff_set_pkg::ff_out_t   sr_o,
   output var  ff_set_pkg::ff_out_t   jk_o,
   output var  ff_set_pkg::ff_out_t   latch_o,
   output var  ff_set_pkg::ff_out_t   dff_o
);

   // Every input bit is a pin level; all are synchronised together
   logic [ff_set_pkg::IN_WIDTH-1:0] raw_in;    // Packed pin levels
   logic [ff_set_pkg::IN_WIDTH-1:0] lvl_in;    // Synchronised levels
   logic [ff_set_pkg::IN_WIDTH-1:0] old_in;    // One cycle older levels

   ff_set_pkg::sr_in_t    sr_s,    sr_p;       // Set/clear now and before
   ff_set_pkg::jk_in_t    jk_s,    jk_p;       // Two-command now and before
   ff_set_pkg::latch_in_t latch_s, latch_p;    // Latch now and before
   ff_set_pkg::dff_in_t   dff_s,   dff_p;      // Data element now and before

   assign raw_in = {sr_i, jk_i, latch_i, dff_i};

   // Pins cross into the clock domain through two flip-flops
   level_sync #(
      .WIDTH   (ff_set_pkg::IN_WIDTH)
   ) u_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i (raw_in),
      .level_o (lvl_in),
      .prev_o  (old_in)
   );

   assign {sr_s, jk_s, latch_s, dff_s} = lvl_in;
   assign {sr_p, jk_p, latch_p, dff_p} = old_in;

   // Stage clock edges of the set/clear, two-command and data elements, seen in the same cycle as the synchronised level
   logic sr_rise, sr_fall;
   logic jk_rise, jk_fall;
   logic dff_rise, dff_fall;

   assign sr_rise  =  sr_s.stage_clock  & ~sr_p.stage_clock;
   assign sr_fall  = ~sr_s.stage_clock  &  sr_p.stage_clock;
   assign jk_rise  =  jk_s.stage_clock  & ~jk_p.stage_clock;
   assign jk_fall  = ~jk_s.stage_clock  &  jk_p.stage_clock;
   assign dff_rise =  dff_s.stage_clock & ~dff_p.stage_clock;
   assign dff_fall = ~dff_s.stage_clock &  dff_p.stage_clock;

   // Set/clear element state
   ff_set_pkg::sr_cmd_t sr_cmd_q, sr_cmd_d;    // Master stage
   ff_set_pkg::ff_out_t sr_out_q, sr_out_d;    // Slave stage and outputs

   // Set/clear element next state
   always_comb begin
      sr_cmd_d = sr_cmd_q;
      sr_out_d = sr_out_q;
      // Master takes the pending command on the rise
      if (sr_rise) begin
         if (sr_s.clocked_set_cmd && !sr_s.clocked_clear_cmd) begin
            sr_cmd_d = ff_set_pkg::SR_SET;
         end else if (sr_s.clocked_clear_cmd && !sr_s.clocked_set_cmd) begin
            sr_cmd_d = ff_set_pkg::SR_CLEAR;
         end else begin
            // Both together is undefined; holding is the quiet choice
            sr_cmd_d = ff_set_pkg::SR_HOLD;
         end
      end
      // Slave carries out the command on the fall
      if (sr_fall) begin
         unique case (sr_cmd_q)
            ff_set_pkg::SR_SET: begin
               sr_out_d.q = 1'b1;
            end
            ff_set_pkg::SR_CLEAR: begin
               sr_out_d.q = 1'b0;
            end
            ff_set_pkg::SR_HOLD: begin
               sr_out_d.q = sr_out_q.q;
            end
            default: begin
               sr_out_d.q = sr_out_q.q;
            end
         endcase
      end
      // Force inputs win over any clocked action; force set has priority
      if (sr_s.force_set) begin
         sr_out_d.q = 1'b1;
      end else if (sr_s.force_clear) begin
         sr_out_d.q = 1'b0;
      end
      sr_out_d.q_n = ~sr_out_d.q;
   end

   // Set/clear element registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sr_cmd_q   <= ff_set_pkg::SR_HOLD;
         sr_out_q.q   <= ff_set_pkg::RESET_Q;
         sr_out_q.q_n <= ff_set_pkg::RESET_Q_N;
      end else begin
         sr_cmd_q <= sr_cmd_d;
         sr_out_q <= sr_out_d;
      end
   end

   // Two-command element state
   ff_set_pkg::jk_cmd_t jk_cmd_q, jk_cmd_d;    // Master stage
   ff_set_pkg::ff_out_t jk_out_q, jk_out_d;    // Slave stage and outputs

   // Two-command element next state
   always_comb begin
      jk_cmd_d = jk_cmd_q;
      jk_out_d = jk_out_q;
      // Master takes the command pair on the rise
      if (jk_rise) begin
         unique case ({jk_s.upper_cmd, jk_s.lower_cmd})
            2'h0: jk_cmd_d = ff_set_pkg::JK_KEEP;
            2'h1: jk_cmd_d = ff_set_pkg::JK_CLEAR;
            2'h2: jk_cmd_d = ff_set_pkg::JK_SET;
            2'h3: jk_cmd_d = ff_set_pkg::JK_TOGGLE;
         endcase
      end
      // Slave applies it on the fall
      if (jk_fall) begin
         unique case (jk_cmd_q)
            ff_set_pkg::JK_KEEP:   jk_out_d.q = jk_out_q.q;
            ff_set_pkg::JK_CLEAR:  jk_out_d.q = 1'b0;
            ff_set_pkg::JK_SET:    jk_out_d.q = 1'b1;
            ff_set_pkg::JK_TOGGLE: jk_out_d.q = ~jk_out_q.q;
         endcase
      end
      // Force inputs win; force set has priority
      if (jk_s.force_set) begin
         jk_out_d.q = 1'b1;
      end else if (jk_s.force_clear) begin
         jk_out_d.q = 1'b0;
      end
      jk_out_d.q_n = ~jk_out_d.q;
   end

   // Two-command element registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         jk_cmd_q     <= ff_set_pkg::JK_KEEP;
         jk_out_q.q   <= ff_set_pkg::RESET_Q;
         jk_out_q.q_n <= ff_set_pkg::RESET_Q_N;
      end else begin
         jk_cmd_q <= jk_cmd_d;
         jk_out_q <= jk_out_d;
      end
   end

   // Latch state; a true latch is avoided so timing stays on one clock
   ff_set_pkg::ff_out_t latch_out_q, latch_out_d;

   // Latch next state: follow while gate high, hold while low
   always_comb begin
      latch_out_d = latch_out_q;
      if (latch_s.stage_clock) begin
         latch_out_d.q = latch_s.sample_value;
      end
      latch_out_d.q_n = ~latch_out_d.q;
   end

   // Latch registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         latch_out_q.q   <= ff_set_pkg::RESET_Q;
         latch_out_q.q_n <= ff_set_pkg::RESET_Q_N;
      end else begin
         latch_out_q <= latch_out_d;
      end
   end

   // Data element state
   logic                dff_master_q, dff_master_d; // Master stage
   ff_set_pkg::ff_out_t dff_out_q,    dff_out_d;    // Slave and outputs

   // Data element next state
   always_comb begin
      dff_master_d = dff_master_q;
      dff_out_d    = dff_out_q;
      // Master samples on the rise
      if (dff_rise) begin
         dff_master_d = dff_s.sample_value;
      end
      // Slave shows the earlier sample on the fall
      if (dff_fall) begin
         dff_out_d.q = dff_master_q;
      end
      // Force inputs win; force set has priority
      if (dff_s.force_set) begin
         dff_out_d.q = 1'b1;
      end else if (dff_s.force_clear) begin
         dff_out_d.q = 1'b0;
      end
      dff_out_d.q_n = ~dff_out_d.q;
   end

   // Data element registers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         dff_master_q  <= ff_set_pkg::RESET_Q;
         dff_out_q.q   <= ff_set_pkg::RESET_Q;
         dff_out_q.q_n <= ff_set_pkg::RESET_Q_N;
      end else begin
         dff_master_q <= dff_master_d;
         dff_out_q    <= dff_out_d;
      end
   end

   // Outputs come straight from the slave registers and the latch register
   assign sr_o    = sr_out_q;
   assign jk_o    = jk_out_q;
   assign latch_o = latch_out_q;
   assign dff_o   = dff_out_q;

endmodule : edge_flip_flop_set

`default_nettype wire

// ### testbench/ff_partner.sv
/* Partner model: the surrounding logic that drives every element input.
   Assumes the bench changes the shared pattern just after a clock edge. */
`default_nettype none

module ff_partner (
   input  wire logic [4:0]            pattern_i,
   output var  ff_set_pkg::sr_in_t    sr_o,
   output var  ff_set_pkg::jk_in_t    jk_o,
   output var  ff_set_pkg::latch_in_t latch_o,
   output var  ff_set_pkg::dff_in_t   dff_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pattern is {clock, first cmd or data, second cmd, force hi, lo}.
   // Clear is masked by set, so the two commands never meet at a rise.
   always_comb begin
      sr_o.clocked_set_cmd   = pattern_i[3];
      sr_o.clocked_clear_cmd = pattern_i[2] & ~pattern_i[3];
      sr_o.stage_clock       = pattern_i[4];
      sr_o.force_set         = pattern_i[1];
      sr_o.force_clear       = pattern_i[0];
      jk_o    = {pattern_i[3:2], pattern_i[4], pattern_i[1:0]};
      latch_o = {pattern_i[3], pattern_i[4]};
      dff_o   = {pattern_i[3], pattern_i[4], pattern_i[1:0]};
   end
endmodule : ff_partner

`default_nettype wire

// ### testbench/edge_flip_flop_set_asserts.sv
/* Checker for the storage element set, bound to the top module.
   Assumes the fixed two-edge lag from input sample to output change. */
`default_nettype none

module edge_flip_flop_set_asserts (
   input wire logic                  mclk_i,
   input wire logic                  reset_i,
   input wire ff_set_pkg::sr_in_t    sr_i,
   input wire ff_set_pkg::jk_in_t    jk_i,
   input wire ff_set_pkg::latch_in_t latch_i,
   input wire ff_set_pkg::dff_in_t   dff_i,
   input wire ff_set_pkg::ff_out_t   sr_o,
   input wire ff_set_pkg::ff_out_t   jk_o,
   input wire ff_set_pkg::ff_out_t   latch_o,
   input wire ff_set_pkg::ff_out_t   dff_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   AST_SR_FORCE_SET:
      assert property (sr_i.force_set |-> ##3 sr_o.q)
      else $error("set/clear element missed force high");
   AST_JK_FORCE_CLEAR:
      assert property (jk_i.force_clear && !jk_i.force_set |-> ##3 !jk_o.q)
      else $error("two-command element missed force low");
   AST_DFF_FORCE_SET:
      assert property (dff_i.force_set |-> ##3 dff_o.q)
      else $error("data element missed force high");
   AST_PAIRS:
      assert property (^sr_o && ^jk_o && ^latch_o && ^dff_o)
      else $error("inverted output equals true output");
   AST_LATCH_FOLLOW:
      assert property (latch_i.stage_clock |->
         ##3 latch_o.q == $past(latch_i.sample_value, 3))
      else $error("latch did not follow data");
   AST_LATCH_HOLD:
      assert property (!latch_i.stage_clock |-> ##3 $stable(latch_o.q))
      else $error("latch changed while gate low");
   AST_SR_KEEP:
      assert property ((!sr_i.stage_clock && !sr_i.force_set
         && !sr_i.force_clear)[*5] |-> $stable(sr_o.q))
      else $error("set/clear output moved without a fall");
   AST_JK_RISE_QUIET:
      assert property ($rose(jk_i.stage_clock) && !jk_i.force_set
         && !jk_i.force_clear |-> ##3 $stable(jk_o.q))
      else $error("two-command output moved on a rise");
   AST_DFF_RISE_QUIET:
      assert property ($rose(dff_i.stage_clock) && !dff_i.force_set
         && !dff_i.force_clear |-> ##3 $stable(dff_o.q))
      else $error("data output moved on a rise");

   // Main scenarios reached
   cover property ($fell(jk_o.q));
   cover property (dff_i.force_set ##3 dff_o.q);
   cover property ($rose(latch_o.q));
endmodule : edge_flip_flop_set_asserts

bind edge_flip_flop_set edge_flip_flop_set_asserts chk_u (
   .mclk_i(mclk_i), .reset_i(reset_i), .sr_i(sr_i), .jk_i(jk_i),
   .latch_i(latch_i), .dff_i(dff_i), .sr_o(sr_o), .jk_o(jk_o),
   .latch_o(latch_o), .dff_o(dff_o));

`default_nettype wire

// ### testbench/tb_edge_flip_flop_set.sv
/* Self-checking bench: each scenario resets, steps the partner and
   compares output pairs. Assumes 125 MHz clock and a 2-edge lag. */
`default_nettype none

module tb_edge_flip_flop_set;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  mclk_i = 1'b0;  // System clock
   logic                  reset_i = 1'b1; // Held at start
   ff_set_pkg::sr_in_t    sr_w;           // Partner to block
   ff_set_pkg::jk_in_t    jk_w;
   ff_set_pkg::latch_in_t la_w;
   ff_set_pkg::dff_in_t   df_w;
   ff_set_pkg::ff_out_t   sr_q;           // Block outputs
   ff_set_pkg::ff_out_t   jk_q;
   ff_set_pkg::ff_out_t   la_q;
   ff_set_pkg::ff_out_t   df_q;
   int                    err_count = 0;
   int                    check_count = 0;

   // 8 ns period
   always #4 mclk_i = ~mclk_i;

   logic [4:0]            pat = 5'h00;    // Pattern fanned out by partner

   ff_partner pu (.pattern_i(pat), .sr_o(sr_w), .jk_o(jk_w),
      .latch_o(la_w), .dff_o(df_w));
   edge_flip_flop_set dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
      .sr_i(sr_w), .jk_i(jk_w), .latch_i(la_w), .dff_i(df_w),
      .sr_o(sr_q), .jk_o(jk_q), .latch_o(la_q), .dff_o(df_q));

   // Pair must be {e, ~e}, so the inverted output is always judged too
   task automatic chk(input ff_set_pkg::ff_out_t got, input logic e);
      ff_set_pkg::ff_out_t exp;
      exp = {e, ~e};
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One step: drive v on an edge and hold it 6 cycles, well past the
   // two-cycle minimum and the two-edge lag, then let outputs settle
   task automatic step(input logic [4:0] v);
      @(posedge mclk_i);
      pat <= v;
      repeat (6) @(posedge mclk_i);
      #2;
   endtask : step

   // Mid-run reset with idle inputs; every element must be low
   task automatic rst;
      @(posedge mclk_i);
      reset_i <= 1'b1;
      step(5'h00);
      @(posedge mclk_i);
      reset_i <= 1'b0;
      #2;
      chk(sr_q, 1'b0);
      chk(jk_q, 1'b0);
      chk(la_q, 1'b0);
      chk(df_q, 1'b0);
   endtask : rst

   // Set taken on rise, applied on fall; empty rise keeps the output
   task automatic t_sr;
      rst();
      step(5'h08);
      step(5'h18);
      chk(sr_q, 1'b0);
      step(5'h08);
      chk(sr_q, 1'b1);
      step(5'h10);
      step(5'h00);
      chk(sr_q, 1'b1);
      step(5'h14);
      step(5'h04);
      chk(sr_q, 1'b0);
   endtask : t_sr

   // Every command pair, toggle twice in a row
   task automatic t_jk;
      logic [1:0] code [5];
      logic       q;
      code = '{2'h2, 2'h0, 2'h3, 2'h3, 2'h1};
      q = 1'b0;
      rst();
      foreach (code[i]) begin
         step({1'b0, code[i], 2'h0});
         step({1'b1, code[i], 2'h0});
         chk(jk_q, q);
         step({1'b0, code[i], 2'h0});
         case (code[i])
            2'h1: q = 1'b0;
            2'h2: q = 1'b1;
            2'h3: q = ~q;
            default: q = q;
         endcase
         chk(jk_q, q);
      end
   endtask : t_jk

   // Data changes while the clock is high: latch follows, master holds
   task automatic t_data;
      rst();
      step(5'h08);
      chk(la_q, 1'b0);
      step(5'h18);
      chk(df_q, 1'b0);
      chk(la_q, 1'b1);
      step(5'h10);
      chk(la_q, 1'b0);
      step(5'h00);
      chk(df_q, 1'b1);
      step(5'h08);
      chk(la_q, 1'b0);
   endtask : t_data

   // Force wins over a fall that would apply a low master
   task automatic t_force;
      rst();
      step(5'h02);
      chk(sr_q, 1'b1);
      chk(jk_q, 1'b1);
      step(5'h12);
      step(5'h02);
      chk(df_q, 1'b1);
      step(5'h01);
      chk(sr_q, 1'b0);
      chk(jk_q, 1'b0);
      chk(df_q, 1'b0);
   endtask : t_force

   // Verdict and end of run
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      repeat (5) @(posedge mclk_i);
      reset_i <= 1'b0;
      t_sr();
      t_jk();
      t_data();
      t_force();
      close_out();
   end

   // Watchdog: the run needs about 250 cycles
   initial begin
      repeat (5000) @(posedge mclk_i);
      err_count++;
      close_out();
   end
endmodule : tb_edge_flip_flop_set

`default_nettype wire
